// ==== design/spo_pkg.sv ====
`default_nettype none
package spo_pkg;
   // Register byte offsets.
   localparam logic [11:0] OFF_RD_QOS      = 12'h100;
   localparam logic [11:0] OFF_WR_QOS      = 12'h104;
   localparam logic [11:0] OFF_ISSUE       = 12'h108;
   localparam logic [11:0] OFF_SPLIT       = 12'h110;
   localparam logic [11:0] OFF_WR_THRESH   = 12'h040;
   localparam logic [11:0] OFF_RSV_GAP     = 12'h10c;
   localparam logic [11:0] OFF_RSV_TOP     = 12'h114;
   // Field positions.
   localparam int          BIT_RD_ONE      = 0;
   localparam int          BIT_WR_ONE      = 1;
   // Reset values.
   localparam logic [1:0]  RST_ISSUE       = 2'h0;
   localparam logic        RST_SPLIT       = 1'h0;
   localparam logic [3:0]  RST_QOS_DEF     = 4'h0;
   localparam logic [3:0]  RST_THRESH_DEF  = 4'h0;
   // Htrans codes.
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ      = 2'h3;

   // Bus request as captured in the address phase.
   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
   } spo_req_t;

   // Overrides presented to the datapath.
   typedef struct packed {
      logic       rd_one;
      logic       wr_one;
      logic       long_ok;
      logic [3:0] rd_qos;
      logic [3:0] wr_qos;
      logic [3:0] wr_thresh;
   } spo_ctl_t;

   // Byte address decode used by read mux and write enables.
   function automatic logic spo_hit(input logic [11:0] a, input logic [11:0] off);
      return a[11:2] == off[11:2];
   endfunction
endpackage
`default_nettype wire

// ==== design/spo_regs.sv ====
// Summary of operation
// - Issue-limit bit 0 set limits the block to one outstanding read.
// - Issue-limit bit 1 set limits the block to one outstanding write; both active high.
// - The one-bit burst split register at 0x110 exists only when downsizing to AXI4.
// - Split bit 0 forces long bursts to be broken so none appear at the output.
// - Split bit 1 lets long bursts pass through unchanged.
// - Without the programmer view the split bit behaves as its default, so no long bursts.
// - The write FIFO threshold resets to its build-time value.
// - With programmable QoS, read and write QoS reset to build-time values.
// - A four-bit read QoS at 0x100 and write QoS at 0x104 exist only with programmable QoS.
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module spo_regs #(
   parameter bit         HAS_PROG_VIEW = 1'b1,
   parameter bit         DOWNSIZE_AXI4 = 1'b1,
   parameter bit         QOS_PROG      = 1'b1,
   parameter logic [3:0] QOS_RD_INIT   = spo_pkg::RST_QOS_DEF,
   parameter logic [3:0] QOS_WR_INIT   = spo_pkg::RST_QOS_DEF,
   parameter logic [3:0] THRESH_INIT   = spo_pkg::RST_THRESH_DEF
) (
   // Clock and reset.
   input  wire logic             hclk,
   input  wire logic             hresetn,
   // AHB-Lite slave.
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output var  logic [31:0]      hrdata,
   output var  logic             hreadyout,
   output var  logic             hresp,
   // Controls to the datapath.
   output var  spo_pkg::spo_ctl_t ctl
);
   // Registered state and the values it takes at the next edge.
   spo_pkg::spo_req_t req_reg, req_next;
   logic              wph_reg, wph_next;
   logic [1:0]        iss_reg, iss_next;
   logic              split_reg, split_next;
   logic [3:0]        rq_reg, rq_next, wq_reg, wq_next;
   logic [31:0]       rd_reg, rd_next;
   spo_pkg::spo_ctl_t ctl_next;
   logic              take;
   logic              hreadyout_next, hresp_next;

   // A transfer is taken when selected, active and the bus is ready.
   assign take = hsel && hready && (htrans == spo_pkg::HTRANS_NONSEQ || htrans == spo_pkg::HTRANS_SEQ);

   // Next-state logic; registers answer with zero wait states.
   always_comb begin
      req_next   = req_reg;
      wph_next   = 1'b0;
      iss_next   = iss_reg;
      split_next = split_reg;
      rq_next    = rq_reg;
      wq_next    = wq_reg;
      rd_next    = rd_reg;
      // Write data phase first, so a read whose address phase overlaps it sees the new value.
      // Unmapped and reserved offsets fall through untouched.
      if (wph_reg) begin
         if (spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_ISSUE)) begin
            iss_next = hwdata[1:0];
         end
         if (DOWNSIZE_AXI4 && HAS_PROG_VIEW && spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_SPLIT)) begin
            split_next = hwdata[0];
         end
         if (QOS_PROG && spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_RD_QOS)) begin
            rq_next = hwdata[3:0];
         end
         if (QOS_PROG && spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_WR_QOS)) begin
            wq_next = hwdata[3:0];
         end
      end
      // Address phase of the next transfer.
      if (take) begin
         req_next.addr = haddr[11:0];
         req_next.wr   = hwrite;
         wph_next      = hwrite;
         // Read data is prepared here so hrdata leaves a flop; it comes from the next values.
         rd_next = 32'h0000_0000;
         if (spo_pkg::spo_hit(haddr[11:0], spo_pkg::OFF_ISSUE)) begin
            rd_next[1:0] = iss_next;
         end
         if (DOWNSIZE_AXI4 && HAS_PROG_VIEW && spo_pkg::spo_hit(haddr[11:0], spo_pkg::OFF_SPLIT)) begin
            rd_next[0] = split_next;
         end
         if (QOS_PROG && spo_pkg::spo_hit(haddr[11:0], spo_pkg::OFF_RD_QOS)) begin
            rd_next[3:0] = rq_next;
         end
         if (QOS_PROG && spo_pkg::spo_hit(haddr[11:0], spo_pkg::OFF_WR_QOS)) begin
            rd_next[3:0] = wq_next;
         end
      end
   end

   // Control outputs; absent registers present their defaults.
   always_comb begin
      ctl_next.rd_one    = iss_next[spo_pkg::BIT_RD_ONE];
      ctl_next.wr_one    = iss_next[spo_pkg::BIT_WR_ONE];
      ctl_next.long_ok   = (DOWNSIZE_AXI4 && HAS_PROG_VIEW) ? split_next : spo_pkg::RST_SPLIT;
      ctl_next.rd_qos    = rq_next;
      ctl_next.wr_qos    = wq_next;
      // The threshold is not bus-mapped in this block, so its build value is passed on as it stands.
      ctl_next.wr_thresh = THRESH_INIT;
   end

   // State registers; build-time values load at reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_reg   <= '0;
         wph_reg   <= 1'b0;
         iss_reg   <= spo_pkg::RST_ISSUE;
         split_reg <= spo_pkg::RST_SPLIT;
         rq_reg    <= QOS_RD_INIT;
         wq_reg    <= QOS_WR_INIT;
         rd_reg    <= 32'h0000_0000;
         ctl       <= '{rd_one: 1'b0, wr_one: 1'b0, long_ok: spo_pkg::RST_SPLIT,
                        rd_qos: QOS_RD_INIT, wr_qos: QOS_WR_INIT, wr_thresh: THRESH_INIT};
      end else begin
         req_reg   <= req_next;
         wph_reg   <= wph_next;
         iss_reg   <= iss_next;
         split_reg <= split_next;
         rq_reg    <= rq_next;
         wq_reg    <= wq_next;
         rd_reg    <= rd_next;
         ctl       <= ctl_next;
      end
   end

   // Zero-wait OKAY slave: every offset, reserved or absent, answers at once without error.
   always_comb begin
      hreadyout_next = 1'b1;
      hresp_next     = 1'b0;
   end

   // Bus response registers, so that the answer leaves flops like every other output.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= hreadyout_next;
         hresp     <= hresp_next;
      end
   end
   assign hrdata = rd_reg;

   // Issue-limit writes reach the controls at the edge that closes their data phase.
   issue_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wph_reg && spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_ISSUE)
      |=> ctl.rd_one == $past(hwdata[0]) && ctl.wr_one == $past(hwdata[1]))
      else $error("issue override not applied");
   // Software must read back exactly the limits that the datapath obeys.
   issue_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && spo_pkg::spo_hit(haddr[11:0], spo_pkg::OFF_ISSUE)
      |=> hrdata == {30'h0, ctl.wr_one, ctl.rd_one})
      else $error("issue readback wrong");

   // Without the register, long bursts must stay forbidden whatever software writes.
   split_default_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !(DOWNSIZE_AXI4 && HAS_PROG_VIEW) |-> !ctl.long_ok)
      else $error("long bursts allowed without register");
   split_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wph_reg && DOWNSIZE_AXI4 && HAS_PROG_VIEW && spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_SPLIT)
      |=> ctl.long_ok == $past(hwdata[0]))
      else $error("split control not applied");
   // An absent split register reads zero; a present one reads the live control.
   split_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && spo_pkg::spo_hit(haddr[11:0], spo_pkg::OFF_SPLIT)
      |=> hrdata == {31'h0, ctl.long_ok && DOWNSIZE_AXI4 && HAS_PROG_VIEW})
      else $error("split readback wrong");

   // The threshold is fixed at build time; nothing on the bus may move it.
   thresh_const_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctl.wr_thresh == THRESH_INIT)
      else $error("threshold lost build value");

   // Both QoS values read back and write through to the datapath.
   qos_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && spo_pkg::spo_hit(haddr[11:0], spo_pkg::OFF_RD_QOS)
      |=> hrdata == (QOS_PROG ? {28'h0, ctl.rd_qos} : 32'h0))
      else $error("read qos readback wrong");
   qos_wr_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && spo_pkg::spo_hit(haddr[11:0], spo_pkg::OFF_WR_QOS)
      |=> hrdata == (QOS_PROG ? {28'h0, ctl.wr_qos} : 32'h0))
      else $error("write qos readback wrong");
   qos_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wph_reg && QOS_PROG && spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_RD_QOS)
      |=> ctl.rd_qos == $past(hwdata[3:0]))
      else $error("read qos write not applied");
   qos_wr_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wph_reg && QOS_PROG && spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_WR_QOS)
      |=> ctl.wr_qos == $past(hwdata[3:0]))
      else $error("write qos write not applied");
   // QoS holds its build-time or last written value until the next write.
   qos_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !wph_reg |=> $stable(rq_reg) && $stable(wq_reg))
      else $error("qos changed without write");

   // Reserved offsets read zero, change nothing and still answer OKAY at once.
   reserved_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite && (spo_pkg::spo_hit(haddr[11:0], spo_pkg::OFF_RSV_GAP)
                          || haddr[11:0] >= spo_pkg::OFF_RSV_TOP)
      |=> hrdata == 32'h0)
      else $error("reserved read not zero");
   reserved_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wph_reg && (spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_RSV_GAP)
                  || req_reg.addr >= spo_pkg::OFF_RSV_TOP)
      |=> $stable(iss_reg) && $stable(split_reg) && $stable(rq_reg) && $stable(wq_reg))
      else $error("reserved write had effect");
   bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus answer not zero-wait okay");

   // Main scenarios that the bench should reach.
   cov_issue_c: cover property (@(posedge hclk) ctl.rd_one && ctl.wr_one);
   cov_long_c: cover property (@(posedge hclk) ctl.long_ok);
   cov_rd_c: cover property (@(posedge hclk) take && !hwrite);
   cov_qos_c: cover property (@(posedge hclk) wph_reg && spo_pkg::spo_hit(req_reg.addr, spo_pkg::OFF_WR_QOS));
   cov_resv_c: cover property (@(posedge hclk) take && hwrite && haddr[11:0] >= spo_pkg::OFF_RSV_TOP);
endmodule
`default_nettype wire

// ==== test/spo_sw_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Software side: a single-transfer AHB-Lite master that waits for hready.
module spo_sw_model (
   // Clock.
   input  wire logic        hclk,
   // Bus out.
   output var  logic        hsel,
   output var  logic [31:0] haddr,
   output var  logic [1:0]  htrans,
   output var  logic        hwrite,
   output var  logic [2:0]  hsize,
   output var  logic [31:0] hwdata,
   // Bus in.
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   initial begin
      {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
   end
   // One word transfer; the data bus is inverted afterwards so stale data never looks valid.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= spo_pkg::HTRANS_NONSEQ;
      haddr  <= {20'h0, a};
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hwdata <= ~d;
      #1;
   endtask
endmodule
`default_nettype wire

// ==== test/slave_port_override_regs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module slave_port_override_regs_tb;
   logic hclk, hresetn, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, hrdata_np, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   spo_pkg::spo_ctl_t ctl, ctl_np;
   int fail_count = 0, comparisons = 0, cycles = 0;
   // Build-time values are non-zero so a fixed-constant reset would be caught.
   spo_regs #(.QOS_RD_INIT(4'ha), .QOS_WR_INIT(4'h5), .THRESH_INIT(4'hc)) u_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .ctl(ctl));
   // Second copy without the programmer view shares the bus but stays silent.
   spo_regs #(.HAS_PROG_VIEW(1'b0)) u_dut_nopv (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata_np),
      .hreadyout(), .hresp(), .ctl(ctl_np));
   spo_sw_model u_sw (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
   // Clock and a hang limit well above the hundred or so cycles the tests need.
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic final_report();
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic t_reset();
      `CHK("ctl", 15'h0a5c, {ctl.rd_one, ctl.wr_one, ctl.long_ok, ctl.rd_qos, ctl.wr_qos, ctl.wr_thresh})
      u_sw.xfer(1'b0, 12'h100, 32'h0, q);
      `CHK("rd_qos", 32'ha, q)
      u_sw.xfer(1'b0, 12'h104, 32'h0, q);
      `CHK("wr_qos", 32'h5, q)
      u_sw.xfer(1'b0, 12'h110, 32'h0, q);
      `CHK("split", 32'h0, q)
   endtask
   task automatic t_issue();
      for (int i = 0; i < 4; i++) begin
         u_sw.xfer(1'b1, 12'h108, i, q);
         `CHK("rd_one", i[0], ctl.rd_one)
         `CHK("wr_one", i[1], ctl.wr_one)
         u_sw.xfer(1'b0, 12'h108, 32'h0, q);
         `CHK("issue", i, q)
      end
   endtask
   task automatic t_split();
      u_sw.xfer(1'b1, 12'h110, 32'h1, q);
      `CHK("long_ok", 1'b1, ctl.long_ok)
      `CHK("nopv", 1'b0, ctl_np.long_ok)
      u_sw.xfer(1'b0, 12'h110, 32'h0, q);
      `CHK("split", 32'h1, q)
      `CHK("nopv_rd", 32'h0, hrdata_np)
      u_sw.xfer(1'b1, 12'h110, 32'h0, q);
      `CHK("long_ok", 1'b0, ctl.long_ok)
   endtask
   task automatic t_qos_resv();
      logic [11:0] ra[3] = '{12'h10c, 12'h114, 12'hffc};
      u_sw.xfer(1'b1, 12'h100, 32'h3, q);
      u_sw.xfer(1'b1, 12'h104, 32'h9, q);
      `CHK("qos", 8'h39, {ctl.rd_qos, ctl.wr_qos})
      foreach (ra[k]) begin
         u_sw.xfer(1'b1, ra[k], 32'hffffffff, q);
         u_sw.xfer(1'b0, ra[k], 32'h0, q);
         `CHK("resv", 32'h0, q)
         `CHK("ctl", 11'h639, {ctl.rd_one, ctl.wr_one, ctl.long_ok, ctl.rd_qos, ctl.wr_qos})
         `CHK("hresp", 1'b0, hresp)
         `CHK("hready", 1'b1, hready)
      end
   endtask
   // A reset in mid-run must bring back the build-time values over what software wrote.
   task automatic t_midrun_reset();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      t_reset();
   endtask
   // Reset for 20 cycles, then the scenarios in turn.
   initial begin
      hresetn = 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
      t_reset();
      t_issue();
      t_split();
      t_qos_resv();
      t_midrun_reset();
      final_report();
   end
endmodule
`default_nettype wire
